// File: core/dpfsb_bank.sv
/*
 * sticky diagnostic and supply fault flags behind a wishbone classic
 * slave, with clear, interrupt status, mask and threshold registers.
 * assumes diagnostic strobes come from logic on clk_i and supply fault
 * levels come straight from analog comparators, asynchronous to clk_i.
 */
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module dpfsb_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic meas_valid_i,
    input wire logic [3:0] meas_cell_i,
    input wire logic meas_cmp_en_i,
    input wire logic meas_ow_en_i,
    input wire logic [15:0] primary_cell_measurement_i,
    input wire logic [15:0] auxiliary_cell_measurement_i,
    input wire logic [15:0] balance_openwire_fail_i,
    input wire logic [15:0] balance_switch_fail_i,
    input wire logic comp_abort_i,
    input wire logic filter_check_fail_i,
    input wire logic [7:0] supply_fault_i
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    localparam int NR = dpfsb_pkg::FLAG_REGS;
    logic [7:0] flag_r [0:NR-1];
    logic [7:0] set_vec [0:NR-1];
    logic [NR-1:0] clr_hit;
    logic [NR-1:0] new_evt;
    logic [NR-1:0] stat_r;
    logic [NR-1:0] mask_r;
    logic [4:0] cmp_thr_r;
    logic [3:0] openwire_threshold_r;
    logic [7:0] pwr_q1_r;
    logic [7:0] pwr_q2_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic irq_r;
    logic [31:0] rd_val;
    logic req;
    logic wr;
    logic [11:0] idx;
    logic [15:0] cell_hot;
    logic cmp_fail;
    logic ow_fail;
    logic cmp_hit;
    logic ow_hit;

    // ---------------------------------------------------------------
    // decoding helpers
    // ---------------------------------------------------------------
    function automatic dpfsb_pkg::dpfsb_slot_type slot_of(input logic [11:0] a);
        slot_of = dpfsb_pkg::SLOT_NONE;
        for (int i = 0; i < NR; i++) begin
            if (a == dpfsb_pkg::FLAG_IDX[i]) begin
                slot_of = dpfsb_pkg::dpfsb_slot_type'(i);
            end
        end
    endfunction : slot_of

    // write-one mask for a 10-bit control word, honouring byte lanes
    function automatic logic [NR-1:0] lane_bits(input logic [31:0] d,
                                                 input logic [3:0] s);
        lane_bits = d[NR-1:0] & {{2{s[1]}}, {8{s[0]}}};
    endfunction : lane_bits

    assign idx = wb_adr_i[13:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = req && wb_we_i;
    assign cell_hot = 16'h0001 << meas_cell_i;

    // ---------------------------------------------------------------
    // measurement checks
    // ---------------------------------------------------------------
    dpfsb_cmp u_cmp (
        .primary_i(primary_cell_measurement_i),
        .aux_i(auxiliary_cell_measurement_i),
        .cmp_thr_i(cmp_thr_r),
        .openwire_threshold_i(openwire_threshold_r),
        .cmp_fail_o(cmp_fail),
        .ow_fail_o(ow_fail)
    );
    assign cmp_hit = meas_valid_i && meas_cmp_en_i && cmp_fail;
    assign ow_hit = meas_valid_i && meas_ow_en_i && ow_fail;

    // ---------------------------------------------------------------
    // supply fault synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q1_r <= dpfsb_pkg::FLAG_RST;
            pwr_q2_r <= dpfsb_pkg::FLAG_RST;
        end else begin
            pwr_q1_r <= supply_fault_i;
            pwr_q2_r <= pwr_q1_r;
        end
    end

    // ---------------------------------------------------------------
    // set sources per slot
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NR; i++) begin
            set_vec[i] = 8'h00;
        end
        if (cmp_hit) begin
            set_vec[dpfsb_pkg::S_CELL_HI] = cell_hot[15:8];
            set_vec[dpfsb_pkg::S_CELL_LO] = cell_hot[7:0];
        end
        if (ow_hit) begin
            set_vec[dpfsb_pkg::S_VCOW_HI] = cell_hot[15:8];
            set_vec[dpfsb_pkg::S_VCOW_LO] = cell_hot[7:0];
        end
        set_vec[dpfsb_pkg::S_CBOW_HI] = balance_openwire_fail_i[15:8];
        set_vec[dpfsb_pkg::S_CBOW_LO] = balance_openwire_fail_i[7:0];
        set_vec[dpfsb_pkg::S_CBFET_HI] = balance_switch_fail_i[15:8];
        set_vec[dpfsb_pkg::S_CBFET_LO] = balance_switch_fail_i[7:0];
        set_vec[dpfsb_pkg::S_MISC][dpfsb_pkg::ABORT_BIT] = comp_abort_i;
        set_vec[dpfsb_pkg::S_MISC][dpfsb_pkg::FILTER_BIT] = filter_check_fail_i;
        // a fault still present after a clear sets the flag again
        set_vec[dpfsb_pkg::S_PWR] = pwr_q2_r;
    end

    always_comb begin
        clr_hit = '0;
        if (wr && idx == dpfsb_pkg::IDX_CLEAR) begin
            clr_hit = lane_bits(wb_dat_i, wb_sel_i);
        end
        for (int i = 0; i < NR; i++) begin
            new_evt[i] = |(set_vec[i] & ~flag_r[i]);
        end
    end

    // ---------------------------------------------------------------
    // sticky flags, set wins over clear
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NR; i++) begin
                flag_r[i] <= dpfsb_pkg::FLAG_RST;
            end
        end else begin
            for (int i = 0; i < NR; i++) begin
                flag_r[i] <= (flag_r[i] & ~{8{clr_hit[i]}}) | set_vec[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= dpfsb_pkg::IRQ_RST;
        end else if (wr && idx == dpfsb_pkg::IDX_IRQ_STAT) begin
            stat_r <= (stat_r & ~lane_bits(wb_dat_i, wb_sel_i)) | new_evt;
        end else begin
            stat_r <= stat_r | new_evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= dpfsb_pkg::IRQ_RST;
        end else if (wr && idx == dpfsb_pkg::IDX_IRQ_MASK) begin
            mask_r <= (mask_r & ~{{2{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})
                | lane_bits(wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // ---------------------------------------------------------------
    // thresholds
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_thr_r <= dpfsb_pkg::CMP_THR_RST;
            openwire_threshold_r <= dpfsb_pkg::OPENWIRE_THRESHOLD_RST;
        end else if (wr && wb_sel_i[0]) begin
            if (idx == dpfsb_pkg::IDX_CMP_THR) begin
                cmp_thr_r <= wb_dat_i[4:0];
            end else if (idx == dpfsb_pkg::IDX_OPENWIRE_THRESHOLD) begin
                openwire_threshold_r <= wb_dat_i[3:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // read mux and bus answer
    // ---------------------------------------------------------------
    always_comb begin
        dpfsb_pkg::dpfsb_slot_type s;
        s = slot_of(idx);
        rd_val = 32'h0000_0000;
        if (s != dpfsb_pkg::SLOT_NONE) begin
            rd_val = {24'h00_0000, flag_r[s]};
        end else if (idx == dpfsb_pkg::IDX_IRQ_STAT) begin
            rd_val = {22'h00_0000, stat_r};
        end else if (idx == dpfsb_pkg::IDX_IRQ_MASK) begin
            rd_val = {22'h00_0000, mask_r};
        end else if (idx == dpfsb_pkg::IDX_CMP_THR) begin
            rd_val = {27'h000_0000, cmp_thr_r};
        end else if (idx == dpfsb_pkg::IDX_OPENWIRE_THRESHOLD) begin
            rd_val = {28'h000_0000, openwire_threshold_r};
        end
    end

    // every address answers; unmapped reads give zero, writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (req && !wb_we_i) begin
                dat_r <= rd_val;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o = irq_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    logic [15:0] cell_flags;
    logic [15:0] vcow_flags;
    logic [15:0] cbow_flags;
    logic [15:0] cbfet_flags;
    assign cell_flags = {flag_r[dpfsb_pkg::S_CELL_HI], flag_r[dpfsb_pkg::S_CELL_LO]};
    assign vcow_flags = {flag_r[dpfsb_pkg::S_VCOW_HI], flag_r[dpfsb_pkg::S_VCOW_LO]};
    assign cbow_flags = {flag_r[dpfsb_pkg::S_CBOW_HI], flag_r[dpfsb_pkg::S_CBOW_LO]};
    assign cbfet_flags = {flag_r[dpfsb_pkg::S_CBFET_HI], flag_r[dpfsb_pkg::S_CBFET_LO]};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_cell_flag_set: assert property (
        cmp_hit |=> (cell_flags & $past(cell_hot)) == $past(cell_hot))
        else $error("cell compare flag not set");
    a_cell_no_false: assert property (
        !cmp_hit |=> (cell_flags & ~$past(cell_flags)) == 16'h0000)
        else $error("cell compare flag rose without a failing compare");
    a_vcow_flag_set: assert property (
        ow_hit |=> (vcow_flags & $past(cell_hot)) == $past(cell_hot))
        else $error("open-wire flag not set");
    a_cbow_flag_set: assert property (
        balance_openwire_fail_i != 16'h0000 |=>
            (cbow_flags & $past(balance_openwire_fail_i)) == $past(balance_openwire_fail_i))
        else $error("balance open-wire flag misplaced");
    a_cbfet_flag_set: assert property (
        balance_switch_fail_i != 16'h0000 |=>
            (cbfet_flags & $past(balance_switch_fail_i)) == $past(balance_switch_fail_i))
        else $error("balance switch flag misplaced");
    a_abort_flag_set: assert property (
        comp_abort_i |=> flag_r[dpfsb_pkg::S_MISC][dpfsb_pkg::ABORT_BIT])
        else $error("abort flag not set");
    a_misc_reserved_zero: assert property (
        (flag_r[dpfsb_pkg::S_MISC] & ~dpfsb_pkg::MISC_USED) == 8'h00)
        else $error("reserved misc bit set");
    a_pwr_ground_open: assert property (
        ((supply_fault_i & dpfsb_pkg::PWR_GND_MASK) == dpfsb_pkg::PWR_GND_MASK) [*3] |=>
            (flag_r[dpfsb_pkg::S_PWR] & dpfsb_pkg::PWR_GND_MASK) == dpfsb_pkg::PWR_GND_MASK)
        else $error("ground open flags not set within three cycles");
    a_pwr_ldo_fault: assert property (
        ((supply_fault_i & dpfsb_pkg::PWR_LDO_MASK) == dpfsb_pkg::PWR_LDO_MASK) [*3] |=>
            (flag_r[dpfsb_pkg::S_PWR] & dpfsb_pkg::PWR_LDO_MASK) == dpfsb_pkg::PWR_LDO_MASK)
        else $error("regulator flags not set within three cycles");
    a_pwr_osc_set: assert property (
        supply_fault_i[dpfsb_pkg::PWR_OSC_BIT] [*3] |=>
            flag_r[dpfsb_pkg::S_PWR][dpfsb_pkg::PWR_OSC_BIT])
        else $error("oscillation flag not set within three cycles");
    a_flag_sticky: assert property (
        !clr_hit[dpfsb_pkg::S_PWR] |=>
            (flag_r[dpfsb_pkg::S_PWR] & $past(flag_r[dpfsb_pkg::S_PWR]))
                == $past(flag_r[dpfsb_pkg::S_PWR]))
        else $error("supply flag dropped without a clear");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_filter_flag_set: assert property (
        filter_check_fail_i |=> flag_r[dpfsb_pkg::S_MISC][dpfsb_pkg::FILTER_BIT])
        else $error("filter check flag not set");
    a_vcow_no_false: assert property (
        !ow_hit |=> (vcow_flags & ~$past(vcow_flags)) == 16'h0000)
        else $error("open-wire flag rose without a failing check");
    a_clear_empties: assert property (
        clr_hit[dpfsb_pkg::S_PWR] && set_vec[dpfsb_pkg::S_PWR] == 8'h00 |=>
            flag_r[dpfsb_pkg::S_PWR] == 8'h00)
        else $error("supply flags survived a clear");
    // a clear that meets a fault still present must not hide it
    a_set_beats_clear: assert property (
        clr_hit[dpfsb_pkg::S_PWR] |=>
            (flag_r[dpfsb_pkg::S_PWR] & $past(set_vec[dpfsb_pkg::S_PWR]))
                == $past(set_vec[dpfsb_pkg::S_PWR]))
        else $error("present supply fault lost to a clear");

    // ---------------------------------------------------------------
    // bus, threshold and interrupt assertions
    // ---------------------------------------------------------------
    a_ack_follows_req: assert property (
        req |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_read_data: assert property (
        req && !wb_we_i |=> wb_dat_o == $past(rd_val))
        else $error("read data does not match the addressed register");
    a_thr_hold: assert property (
        !wr |=> cmp_thr_r == $past(cmp_thr_r) && openwire_threshold_r == $past(openwire_threshold_r))
        else $error("threshold changed without a write");
    a_mask_hold: assert property (
        !(wr && idx == dpfsb_pkg::IDX_IRQ_MASK) |=> mask_r == $past(mask_r))
        else $error("interrupt mask changed without a write");
    a_stat_event: assert property (
        new_evt != '0 |=> (stat_r & $past(new_evt)) == $past(new_evt))
        else $error("interrupt status missed a new flag");
    // irq is registered, so it trails status and mask by one cycle
    a_irq_level: assert property (
        irq_o == $past(|(stat_r & mask_r)))
        else $error("interrupt level disagrees with status and mask");

    c_cell_fail: cover property (cmp_hit ##1 cell_flags != 16'h0000);
    c_pwr_fault: cover property (flag_r[dpfsb_pkg::S_PWR] != 8'h00);
    c_irq_rise: cover property ($rose(irq_o));
    c_clear_write: cover property (clr_hit != '0);
    c_set_over_clear: cover property (clr_hit[dpfsb_pkg::S_PWR] && pwr_q2_r != 8'h00);
endmodule : dpfsb_bank

// File: core/dpfsb_cmp.sv
/*
 * per-measurement checks: main versus auxiliary difference against the
 * compare threshold, and main measurement against the open-wire threshold.
 * assumes both measurements are unsigned codes of the same scale.
 */
`timescale 1ns/1ps
module dpfsb_cmp (
    input wire logic [dpfsb_pkg::MEAS_W-1:0] primary_i,
    input wire logic [dpfsb_pkg::MEAS_W-1:0] aux_i,
    input wire logic [4:0] cmp_thr_i,
    input wire logic [3:0] openwire_threshold_i,
    output logic cmp_fail_o,
    output logic ow_fail_o
);
    logic [dpfsb_pkg::MEAS_W-1:0] diff;
    logic [dpfsb_pkg::MEAS_W-1:0] cmp_lim;
    logic [dpfsb_pkg::MEAS_W-1:0] ow_lim;

    // thresholds are coarse codes; scaling keeps them in the measurement unit
    assign cmp_lim = dpfsb_pkg::MEAS_W'(cmp_thr_i) << dpfsb_pkg::CMP_THR_SHIFT;
    assign ow_lim = dpfsb_pkg::MEAS_W'(openwire_threshold_i) << dpfsb_pkg::OPENWIRE_THRESHOLD_SHIFT;
    assign diff = (primary_i >= aux_i) ? primary_i - aux_i : aux_i - primary_i;
    assign cmp_fail_o = diff > cmp_lim;
    assign ow_fail_o = primary_i < ow_lim;
endmodule : dpfsb_cmp

// File: core/dpfsb_pkg.sv
/*
 * constants for the diagnostic and supply fault status bank: register
 * indices, slot order, field positions, reset values and compare scaling.
 * assumes a wishbone classic host with 32-bit data and byte addresses,
 * where the byte address of a register is four times its index.
 */
package dpfsb_pkg;
    // ---------------------------------------------------------------
    // register indices
    // ---------------------------------------------------------------
    localparam int FLAG_REGS = 10;
    localparam logic [11:0] FLAG_IDX [0:FLAG_REGS-1] = '{
        12'h0545, 12'h0546, 12'h0548, 12'h0549, 12'h054b,
        12'h054c, 12'h054e, 12'h054f, 12'h0550, 12'h0552
    };
    localparam logic [11:0] IDX_CLEAR = 12'h0560;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h0561;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h0562;
    localparam logic [11:0] IDX_CMP_THR = 12'h0563;
    localparam logic [11:0] IDX_OPENWIRE_THRESHOLD = 12'h0564;

    // ---------------------------------------------------------------
    // slot order of the flag registers
    // ---------------------------------------------------------------
    localparam int S_CELL_HI = 0;
    localparam int S_CELL_LO = 1;
    localparam int S_VCOW_HI = 2;
    localparam int S_VCOW_LO = 3;
    localparam int S_CBOW_HI = 4;
    localparam int S_CBOW_LO = 5;
    localparam int S_CBFET_HI = 6;
    localparam int S_CBFET_LO = 7;
    localparam int S_MISC = 8;
    localparam int S_PWR = 9;
    typedef logic [3:0] dpfsb_slot_type;
    localparam dpfsb_slot_type SLOT_NONE = 4'hf;

    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int ABORT_BIT = 4;
    localparam int FILTER_BIT = 3;
    localparam logic [7:0] MISC_USED = 8'h18;
    localparam logic [7:0] PWR_GND_MASK = 8'he0;
    localparam logic [7:0] PWR_LDO_MASK = 8'h1d;
    localparam int PWR_OSC_BIT = 1;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [9:0] IRQ_RST = 10'h000;
    localparam logic [4:0] CMP_THR_RST = 5'h00;
    localparam logic [3:0] OPENWIRE_THRESHOLD_RST = 4'h0;

    // ---------------------------------------------------------------
    // measurement scaling
    // ---------------------------------------------------------------
    localparam int MEAS_W = 16;
    localparam int CMP_THR_SHIFT = 4;
    localparam int OPENWIRE_THRESHOLD_SHIFT = 8;
endpackage : dpfsb_pkg

// File: dv/dpfsb_bank_tb.sv
/*
 * self-checking bench for the fault status bank: wishbone classic reads
 * and writes, diagnostic strobes and supply fault levels from the bench.
 * assumes the bank acks one cycle after it takes a request.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module dpfsb_bank_tb;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [13:0] wb_adr_i;
    logic [3:0] wb_sel_i, meas_cell_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic meas_valid_i, meas_cmp_en_i, meas_ow_en_i, comp_abort_i, filter_check_fail_i;
    logic [15:0] pri, aux, bow, bsw;
    logic [7:0] supply_fault_i;
    int err_count = 0;
    int check_count = 0;

    dpfsb_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .meas_valid_i(meas_valid_i), .meas_cell_i(meas_cell_i),
        .meas_cmp_en_i(meas_cmp_en_i), .meas_ow_en_i(meas_ow_en_i),
        .primary_cell_measurement_i(pri), .auxiliary_cell_measurement_i(aux),
        .balance_openwire_fail_i(bow), .balance_switch_fail_i(bsw),
        .comp_abort_i(comp_abort_i), .filter_check_fail_i(filter_check_fail_i),
        .supply_fault_i(supply_fault_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------------
    // bus and stimulus tasks
    // ---------------------------------------------------------------
    task automatic wb_xfer(input logic we, input logic [11:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        // ack is sampled at the edge, so the value seen here is pre-update
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("[FAIL] bus ack expected 1 seen none");
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic chk_reg(input string nm, input logic [11:0] idx, input logic [31:0] exp);
        wb_xfer(1'b0, idx, 32'h0000_0000);
        `CHK(nm, exp, rd)
    endtask : chk_reg

    task automatic meas(input logic [3:0] c, input logic ce, input logic oe,
                        input logic [15:0] p, input logic [15:0] a);
        @(posedge clk_i);
        meas_valid_i <= 1'b1;
        meas_cell_i <= c;
        meas_cmp_en_i <= ce;
        meas_ow_en_i <= oe;
        pri <= p;
        aux <= a;
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
    endtask : meas

    task automatic strobes(input logic [15:0] ow, input logic [15:0] sw, input logic ab,
                           input logic fl);
        @(posedge clk_i);
        bow <= ow;
        bsw <= sw;
        comp_abort_i <= ab;
        filter_check_fail_i <= fl;
        @(posedge clk_i);
        bow <= 16'h0000;
        bsw <= 16'h0000;
        comp_abort_i <= 1'b0;
        filter_check_fail_i <= 1'b0;
    endtask : strobes

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        finish_test();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, meas_valid_i, meas_cmp_en_i, meas_ow_en_i} = '0;
        {comp_abort_i, filter_check_fail_i} = '0;
        wb_adr_i = '0;
        wb_sel_i = '0;
        wb_dat_i = '0;
        meas_cell_i = '0;
        {pri, aux, bow, bsw} = '0;
        supply_fault_i = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < dpfsb_pkg::FLAG_REGS; k++) begin
            chk_reg("flag reset", dpfsb_pkg::FLAG_IDX[k], 32'h0000_0000);
        end
        wb_xfer(1'b1, 12'h545, 32'h0000_00ff);
        chk_reg("read-only write", 12'h545, 32'h0000_0000);
        chk_reg("unmapped", 12'h547, 32'h0000_0000);
        wb_xfer(1'b1, dpfsb_pkg::IDX_IRQ_MASK, 32'h0000_0100);
        chk_reg("irq mask", dpfsb_pkg::IDX_IRQ_MASK, 32'h0000_0100);
        // threshold 1 means a difference of 16 passes and 17 fails
        wb_xfer(1'b1, dpfsb_pkg::IDX_CMP_THR, 32'h0000_0001);
        meas(4'hf, 1'b1, 1'b0, 16'h03e8, 16'h03d7);
        meas(4'h0, 1'b1, 1'b0, 16'h03d7, 16'h03e8);
        meas(4'h8, 1'b1, 1'b0, 16'h03e8, 16'h03d8);
        chk_reg("compare hi", 12'h545, 32'h0000_0080);
        chk_reg("compare lo", 12'h546, 32'h0000_0001);
        wb_xfer(1'b1, dpfsb_pkg::IDX_OPENWIRE_THRESHOLD, 32'h0000_0001);
        meas(4'h9, 1'b0, 1'b1, 16'h00ff, 16'h0000);
        meas(4'h7, 1'b0, 1'b1, 16'h0100, 16'h0000);
        meas(4'h6, 1'b0, 1'b0, 16'h00ff, 16'h0000);
        chk_reg("openwire hi", 12'h548, 32'h0000_0002);
        chk_reg("openwire lo", 12'h549, 32'h0000_0000);
        strobes(16'h8001, 16'h4002, 1'b0, 1'b0);
        chk_reg("bal ow hi", 12'h54b, 32'h0000_0080);
        chk_reg("bal ow lo", 12'h54c, 32'h0000_0001);
        chk_reg("bal sw hi", 12'h54e, 32'h0000_0040);
        chk_reg("bal sw lo", 12'h54f, 32'h0000_0002);
        chk_reg("irq status", dpfsb_pkg::IDX_IRQ_STAT, 32'h0000_00f7);
        `CHK("irq masked", 1'b0, irq_o)
        strobes(16'h0000, 16'h0000, 1'b1, 1'b0);
        repeat (2) @(posedge clk_i);
        `CHK("irq raised", 1'b1, irq_o)
        chk_reg("misc abort", 12'h550, 32'h0000_0010);
        wb_xfer(1'b1, dpfsb_pkg::IDX_IRQ_STAT, 32'h0000_03ff);
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq_o)
        chk_reg("irq status clr", dpfsb_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        strobes(16'h0000, 16'h0000, 1'b0, 1'b1);
        chk_reg("misc both", 12'h550, 32'h0000_0018);
        // supply levels pass a two-flop synchroniser before the flag
        @(posedge clk_i);
        supply_fault_i <= 8'hfd;
        repeat (6) @(posedge clk_i);
        supply_fault_i <= 8'h00;
        repeat (6) @(posedge clk_i);
        chk_reg("supply sticky", 12'h552, 32'h0000_00fd);
        @(posedge clk_i);
        supply_fault_i <= 8'h02;
        repeat (6) @(posedge clk_i);
        wb_xfer(1'b1, dpfsb_pkg::IDX_CLEAR, 32'h0000_0200);
        repeat (2) @(posedge clk_i);
        chk_reg("osc persists", 12'h552, 32'h0000_0002);
        supply_fault_i <= 8'h00;
        repeat (6) @(posedge clk_i);
        wb_xfer(1'b1, dpfsb_pkg::IDX_CLEAR, 32'h0000_03ff);
        for (int k = 0; k < dpfsb_pkg::FLAG_REGS; k++) begin
            chk_reg("flag cleared", dpfsb_pkg::FLAG_IDX[k], 32'h0000_0000);
        end
        finish_test();
    end
endmodule : dpfsb_bank_tb
